/* File: design/rcs_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - After each full byte of a multi-byte write the address steps up by one, wrapping 2 to 0.
// - A string is read in order: read/write bit (0 writes), two address bits, bytes MSB first.
// - The serial line is sampled on each rising edge of the shift clock while the frame is active, except during the data bits of a read.
// - Every transfer is framed by an active frame line, which returns low between transfers.
// - On a read the device drives register bits after the header and releases at frame end.
module rcs_port
  import rcs_pkg::*;
#(
  parameter int unsigned NUM_REGS = RCS_NUM_REGS
) (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       config_frame,
  input  wire logic       config_shift_clock,
  input  wire logic       config_serial_line_in,
  output logic            config_serial_line_out,
  output logic            config_serial_line_oe_n,
  output logic [7:0]      first_config_byte,
  output logic [7:0]      second_config_byte,
  output logic [7:0]      third_config_byte,
  output rcs_mode_e       op_mode,
  output logic            config_update
);
  logic       rst_meta;
  logic       rst_n;
  logic [2:0] pins_s;
  logic       frame_s;
  logic       sclk_s;
  logic       sdat_s;
  logic       sclk_d;
  logic       frame_d;
  logic       rise;
  logic       frame_end;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  rcs_sync #(.WIDTH(3)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({config_frame, config_shift_clock, config_serial_line_in}),
    .sync_out (pins_s)
  );
  assign frame_s = pins_s[2];
  assign sclk_s  = pins_s[1];
  assign sdat_s  = pins_s[0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d  <= 1'b0;
      frame_d <= 1'b0;
    end else if (clk_en) begin
      sclk_d  <= sclk_s;
      frame_d <= frame_s;
    end
  end
  assign rise      = frame_s && sclk_s && !sclk_d;
  assign frame_end = frame_d && !frame_s;

  // shift state
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [1:0] hdrcnt;
  logic       hdr_done;
  logic       rw;
  logic [1:0] addr;
  logic [7:0] shadow [NUM_REGS];
  logic [NUM_REGS-1:0] dirty;
  logic [7:0] live   [NUM_REGS];
  logic [7:0] next_shreg;

  assign next_shreg = {shreg[6:0], sdat_s};

  // header: rw then address, MSB first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdrcnt   <= 2'h0;
      hdr_done <= 1'b0;
      rw       <= RCS_RW_WRITE;
    end else if (clk_en) begin
      if (!frame_s) begin
        hdrcnt   <= 2'h0;
        hdr_done <= 1'b0;
      end else if (rise && !hdr_done) begin
        if (hdrcnt == 2'h0) begin
          rw <= sdat_s;
        end
        if (hdrcnt == 2'h2) begin
          hdr_done <= 1'b1;
        end
        hdrcnt <= hdrcnt + 2'h1;
      end
    end
  end

  // address and data bytes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr   <= RCS_ADDR_FIRST;
      bitcnt <= 3'h0;
      shreg  <= 8'h00;
      dirty  <= '0;
      for (int i = 0; i < NUM_REGS; i++) begin
        shadow[i] <= RCS_CFG_RESET;
      end
    end else if (clk_en) begin
      if (!frame_s) begin
        bitcnt <= 3'h0;
        if (frame_end) begin
          dirty <= '0;
        end
      end else if (rise && !hdr_done) begin
        if (hdrcnt != 2'h0) begin
          addr <= {addr[0], sdat_s};
        end
        if (hdrcnt == 2'h2) begin
          shreg <= live[{addr[0], sdat_s}];
        end
      end else if (rise) begin
        bitcnt <= bitcnt + 3'h1;
        shreg  <= rw ? {shreg[6:0], 1'b0} : next_shreg;
        if (bitcnt == 3'h7) begin
          if (!rw) begin
            shadow[addr] <= next_shreg;
            dirty[addr]  <= 1'b1;
          end
          addr <= (addr == RCS_ADDR_LAST) ? RCS_ADDR_FIRST : addr + 2'h1;
          if (rw) begin
            shreg <= live[(addr == RCS_ADDR_LAST) ? RCS_ADDR_FIRST : addr + 2'h1];
          end
        end
      end
    end
  end

  // live configuration changes only at frame end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        live[i] <= RCS_CFG_RESET;
      end
      config_update <= 1'b0;
    end else if (clk_en) begin
      config_update <= frame_end && (dirty != '0);
      if (frame_end) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          if (dirty[i]) begin
            live[i] <= shadow[i];
          end
        end
      end
    end
  end

  // read drive: on after header, off as soon as frame drops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_serial_line_out  <= 1'b0;
      config_serial_line_oe_n <= 1'b1;
    end else if (clk_en) begin
      if (frame_s && hdr_done && rw) begin
        config_serial_line_oe_n <= 1'b0;
        config_serial_line_out  <= shreg[7];
      end else begin
        config_serial_line_oe_n <= 1'b1;
        config_serial_line_out  <= 1'b0;
      end
    end
  end

  // mode decode from addresses 0 and 1
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_config_byte  <= RCS_CFG_RESET;
      second_config_byte <= RCS_CFG_RESET;
      third_config_byte  <= RCS_CFG_RESET;
      op_mode            <= RCS_MODE_RX_EXT;
    end else if (clk_en) begin
      first_config_byte  <= live[0];
      second_config_byte <= live[1];
      third_config_byte  <= live[2];
      if (live[0] == RCS_RX_EXT_B0 && live[1] == RCS_RX_EXT_B1) begin
        op_mode <= RCS_MODE_RX_EXT;
      end else if (live[0] == RCS_RX_INT_B0 && live[1] == RCS_RX_INT_B1) begin
        op_mode <= RCS_MODE_RX_INT;
      end else if (live[0] == RCS_TX_OOK_B0 && live[1] == RCS_TX_OOK_B1) begin
        op_mode <= RCS_MODE_TX_OOK;
      end else begin
        op_mode <= RCS_MODE_OTHER;
      end
    end
  end
endmodule : rcs_port
`default_nettype wire

/* File: design/rcs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : rcs_sync
`default_nettype wire

/* File: shared/rcs_pkg.sv */
`default_nettype none
package rcs_pkg;
  // configuration string layout
  localparam int unsigned RCS_ADDR_W      = 2;
  localparam int unsigned RCS_BYTE_W      = 8;
  localparam int unsigned RCS_NUM_REGS    = 3;
  localparam logic [1:0]  RCS_ADDR_FIRST  = 2'h0;
  localparam logic [1:0]  RCS_ADDR_LAST   = 2'h2;
  localparam logic        RCS_RW_WRITE    = 1'b0;
  localparam logic        RCS_RW_READ     = 1'b1;
  // reset contents of the three configuration registers
  localparam logic [7:0]  RCS_CFG_RESET   = 8'h00;
  // mode byte patterns at addresses 0 and 1
  localparam logic [7:0]  RCS_RX_EXT_B0   = 8'h00;
  localparam logic [7:0]  RCS_RX_EXT_B1   = 8'h00;
  localparam logic [7:0]  RCS_RX_INT_B0   = 8'h01;
  localparam logic [7:0]  RCS_RX_INT_B1   = 8'h04;
  localparam logic [7:0]  RCS_TX_OOK_B0   = 8'h48;
  localparam logic [7:0]  RCS_TX_OOK_B1   = 8'h20;
  // read data valid after rising edge, at most
  localparam int unsigned RCS_RDVAL_NS    = 90;
  localparam int unsigned RCS_CLK_NS      = 25;
  localparam int unsigned RCS_RDVAL_CYC   = (RCS_RDVAL_NS / RCS_CLK_NS) < 1 ? 1
                                            : RCS_RDVAL_NS / RCS_CLK_NS;
  typedef enum logic [1:0] {
    RCS_MODE_RX_EXT,
    RCS_MODE_RX_INT,
    RCS_MODE_TX_OOK,
    RCS_MODE_OTHER
  } rcs_mode_e;
endpackage : rcs_pkg
`default_nettype wire

/* File: verification/radio_config_serial_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module radio_config_serial_port_bench;
  import rcs_pkg::*;
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        clk_en  = 1'b1;
  logic        frame, sclk, line, dout, oe_n, upd;
  logic [7:0]  b0, b1, b2;
  logic [23:0] rd;
  rcs_mode_e   mode;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          ups = 0;
  always #12.5 sys_clk = ~sys_clk;
  rcs_port rcs_port_inst (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .config_frame(frame), .config_shift_clock(sclk), .config_serial_line_in(line),
    .config_serial_line_out(dout), .config_serial_line_oe_n(oe_n),
    .first_config_byte(b0), .second_config_byte(b1), .third_config_byte(b2),
    .op_mode(mode), .config_update(upd));
  rcs_host rcs_host_inst (.sys_clk(sys_clk), .dev_out(dout), .dev_oe_n(oe_n),
    .frame(frame), .sclk(sclk), .line(line));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (upd === 1'b1) ups <= ups + 1;
    if (cyc == 4000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic t_modes;
    logic [15:0] p [3];
    rcs_mode_e   m [3];
    p = '{16'h0104, 16'h4820, 16'h0000};
    m = '{RCS_MODE_RX_INT, RCS_MODE_TX_OOK, RCS_MODE_RX_EXT};
    for (int k = 0; k < 3; k++) begin
      rcs_host_inst.xfer(RCS_RW_WRITE, RCS_ADDR_FIRST, 2, {p[k], 8'h00}, rd);
      chk(mode, m[k]);
      chk({b0, b1}, p[k]);
    end
    chk(ups, 3);
  endtask : t_modes
  task automatic t_wrap;
    rcs_host_inst.xfer(RCS_RW_WRITE, RCS_ADDR_LAST, 3, 24'ha53c5a, rd);
    chk({b2, b0, b1}, 24'ha53c5a);
  endtask : t_wrap
  task automatic t_read;
    rcs_host_inst.xfer(RCS_RW_READ, 2'h1, 3, 24'h0, rd);
    chk(rd, 24'h5aa53c);
    chk(oe_n, 1'b1);
    chk(ups, 4);
  endtask : t_read
  // a frozen port must miss a whole transfer and keep its mode
  task automatic t_freeze;
    clk_en <= 1'b0;
    rcs_host_inst.xfer(RCS_RW_WRITE, RCS_ADDR_FIRST, 2, {RCS_TX_OOK_B0, RCS_TX_OOK_B1, 8'h00}, rd);
    clk_en <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(mode, RCS_MODE_OTHER);
    chk(b0, 8'h3c);
    chk(ups, 4);
  endtask : t_freeze
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    t_modes();
    t_wrap();
    t_read();
    t_freeze();
    wrap_up();
  end
endmodule : radio_config_serial_port_bench
`default_nettype wire

/* File: verification/rcs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_host
  import rcs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  output logic      frame,
  output logic      sclk,
  output logic      line
);
  logic       drv      = 1'b0;
  logic       dat      = 1'b0;
  logic       last     = 1'b0;
  logic       sleeping = 1'b0;
  logic [7:0] img [3]  = '{default: 8'h00};
  initial frame = 1'b0;
  initial sclk = 1'b0;
  // released line toggles so stale data never reads as valid
  always @(posedge sys_clk) last <= line;
  assign line = !dev_oe_n ? dev_out : drv ? dat : ~last;
  task automatic xfer(input logic rw, input logic [1:0] a, input int n,
                      input logic [23:0] wd, output logic [23:0] rd);
    logic [26:0] s;
    logic [15:0] cfg;
    s = {rw, a, wd};
    rd = 24'h0;
    @(posedge sys_clk);
    frame <= 1'b1;
    // a sleeping radio needs a much longer frame setup
    repeat (sleeping ? 40 : 4) @(posedge sys_clk);
    for (int i = 0; i < 3 + 8 * n; i++) begin
      drv <= !rw || i < 3;
      dat <= s[26 - i];
      repeat (4) @(posedge sys_clk);
      if (i > 2) rd[26 - i] = line;
      sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    frame <= 1'b0;
    drv   <= 1'b0;
    // host keeps its own image to know whether the radio may be asleep
    if (!rw) begin
      for (int b = 0; b < n; b++) begin
        img[(a + b) % 3] = wd[23 - 8 * b -: 8];
      end
    end
    cfg = {img[0], img[1]};
    sleeping = !(cfg inside {{RCS_RX_EXT_B0, RCS_RX_EXT_B1}, {RCS_RX_INT_B0, RCS_RX_INT_B1},
                             {RCS_TX_OOK_B0, RCS_TX_OOK_B1}});
    repeat (8) @(posedge sys_clk);
  endtask : xfer
endmodule : rcs_host
`default_nettype wire

/* File: verification/rcs_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_port_chk
  import rcs_pkg::*;
#(
  parameter int unsigned NUM_REGS = RCS_NUM_REGS
) (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       config_frame,
  input wire logic       config_serial_line_oe_n,
  input wire logic [7:0] first_config_byte,
  input wire logic [7:0] second_config_byte,
  input wire rcs_mode_e  op_mode,
  input wire logic       config_update
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  idle_release_a: assert property (!config_frame [*5] |-> config_serial_line_oe_n)
    else $error("line driven outside frame");
  drive_frame_a: assert property ($fell(config_serial_line_oe_n) |-> $past(config_frame, 8))
    else $error("drive without framed header");
  mode_commit_a: assert property ($changed(op_mode) |-> !config_frame)
    else $error("mode changed inside frame");
  update_pulse_a: assert property (config_update |=> !config_update)
    else $error("update pulse too long");
  tx_decode_a: assert property (config_update ##2 (first_config_byte == RCS_TX_OOK_B0 &&
    second_config_byte == RCS_TX_OOK_B1) |-> op_mode == RCS_MODE_TX_OOK)
    else $error("transmit pattern not decoded");
  rx_int_decode_a: assert property (config_update ##2 (first_config_byte == RCS_RX_INT_B0 &&
    second_config_byte == RCS_RX_INT_B1) |-> op_mode == RCS_MODE_RX_INT)
    else $error("receive pattern not decoded");
  cover property (config_update);
  cover property ($fell(config_serial_line_oe_n));
  cover property (op_mode == RCS_MODE_TX_OOK);
endmodule : rcs_port_chk
bind rcs_port rcs_port_chk #(.NUM_REGS(NUM_REGS)) rcs_port_chk_inst (.*);
`default_nettype wire
